// ---- core/compare_capture_unit.v ----
// Compare unit: timer 2, compare timer, thirteen compare registers, APB slave
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "ccu_consts.vh"
module compare_capture_unit (
  input wire mclk, // System clock, used as oscillator
  input wire rst_n, // Synchronous reset, active low
  input wire psel, // APB select
  input wire penable, // APB access phase
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output wire [31:0] prdata, // APB read data
  output wire pready, // APB ready
  output wire pslverr, // APB error on unmapped address
  input wire timer2_gate_event_input, // Gate or event pin of timer 2
  input wire reload_trigger_input, // Reload trigger pin of timer 2
  output wire [4:0] cc_pin, // Outputs of the five timer 2 registers
  output wire [7:0] cm_pin, // Outputs of the eight compare registers
  output wire [7:0] concurrent_output_pin, // Concurrent outputs
  output wire irq // Interrupt, high while unmasked status set
);

  // Software state
  reg [10:0] ctrl_reg; // Control fields
  reg [15:0] ct_rld_reg; // Compare timer reload
  reg [7:0] cm_en_reg; // Compare register enables
  reg [7:0] cm_sel_reg; // 1: compare register on compare timer
  reg [4:0] cc_en_reg; // Timer 2 register compare enables
  reg [4:0] cc_m1_reg; // Timer 2 register compare mode 1
  reg [15:0] set_compare_register; // Compare mode 2 set value
  reg [15:0] clear_compare_register; // Compare mode 2 clear value
  reg [7:0] set_mask; // Compare mode 2 set mask
  reg [7:0] clear_mask; // Compare mode 2 clear mask
  reg [7:0] ccm_reg; // Concurrent port latch
  reg [7:0] ccm_sh_reg; // Concurrent shadow latch
  reg [7:0] ccm_next; // Next concurrent port latch
  reg [`INT_W-1:0] int_st_reg; // Sticky event status
  reg [`INT_W-1:0] int_msk_reg; // Interrupt mask
  reg [31:0] prdata_reg; // Read data
  reg [31:0] rd_mux; // Read data selection
  reg [15:0] cmp_val_reg [0:12]; // 0 reload, 4 concurrent, 5..12 compare
  integer k; // Reset loop index

  // Clock division and pin sampling
  reg [3:0] mc_cnt_reg; // Oscillator clocks within machine cycle
  reg half_reg; // Toggles each machine cycle for /24
  reg [7:0] ct_div_reg; // Free divider for compare timer
  reg t2_s1_reg; // Gate/event pin, first stage
  reg t2_s2_reg; // Gate/event pin, second stage
  reg t2_smp_reg; // Gate/event pin sampled per machine cycle
  reg rt_s1_reg; // Reload trigger, first stage
  reg rt_s2_reg; // Reload trigger, second stage
  reg rt_prev_reg; // Reload trigger, previous level

  // Internal nets
  wire mc_tick; // One pulse per machine cycle
  wire t2_base; // Timer 2 internal count pulse
  reg t2_tick; // Timer 2 count pulse by source
  wire ct_tick; // Compare timer count pulse
  wire rt_fall; // Reload trigger falling edge
  wire [15:0] t2_cnt; // Timer 2 count
  wire t2_step; // Timer 2 advanced
  wire t2_ovf; // Timer 2 overflow
  wire [15:0] ct_cnt; // Compare timer count
  wire ct_step; // Compare timer advanced
  wire ct_ovf; // Compare timer overflow
  wire [4:0] cc_match; // Timer 2 register matches
  wire [7:0] cm_match; // Compare register matches
  wire set_hit; // Mode 2 set match
  wire clr_hit; // Mode 2 clear match
  wire wr_en; // APB write completes
  wire in_cc; // Address in timer 2 register window
  wire in_cm; // Address in compare register window
  wire mapped; // Address decodes to a register
  wire [`INT_W-1:0] int_ev; // Events of this cycle

  // Prescaler mask: p+1 low ones gives division by 2^(p+1)
  function [7:0] ct_mask;
    input [2:0] p;
    begin
      ct_mask = ~(8'hFE << p);
    end
  endfunction

  // Machine cycle divider and prescalers
  always @(posedge mclk) begin
    if (!rst_n) begin
      mc_cnt_reg <= 4'h0;
      half_reg <= 1'b0;
      ct_div_reg <= 8'h00;
    end else begin
      ct_div_reg <= ct_div_reg + 8'h01;
      if (mc_tick) begin
        mc_cnt_reg <= 4'h0;
        half_reg <= ~half_reg;
      end else begin
        mc_cnt_reg <= mc_cnt_reg + 4'h1;
      end
    end
  end

  assign mc_tick = (mc_cnt_reg == `OSC_PER_MC - 4'h1);
  // Every machine cycle or every second one
  assign t2_base = mc_tick & (~ctrl_reg[`CTRL_T2PS] | half_reg);
  // Compare timer runs off the oscillator through its prescaler
  assign ct_tick = ctrl_reg[`CTRL_CTRUN] & (&(ct_div_reg | ~ct_mask(ctrl_reg[`CTRL_CTPS])));

  // Pin synchronisers and per machine cycle sampling
  always @(posedge mclk) begin
    if (!rst_n) begin
      t2_s1_reg <= 1'b0;
      t2_s2_reg <= 1'b0;
      t2_smp_reg <= 1'b0;
      rt_s1_reg <= 1'b1;
      rt_s2_reg <= 1'b1;
      rt_prev_reg <= 1'b1;
    end else begin
      t2_s1_reg <= timer2_gate_event_input;
      t2_s2_reg <= t2_s1_reg;
      rt_s1_reg <= reload_trigger_input;
      rt_s2_reg <= rt_s1_reg;
      rt_prev_reg <= rt_s2_reg;
      if (mc_tick) begin
        t2_smp_reg <= t2_s2_reg;
      end
    end
  end

  assign rt_fall = rt_prev_reg & ~rt_s2_reg;

  // Timer 2 count source
  always @* begin
    case (ctrl_reg[`CTRL_T2SRC])
      `SRC_TIMER: t2_tick = t2_base;
      `SRC_EVENT: t2_tick = mc_tick & t2_smp_reg & ~t2_s2_reg;
      `SRC_GATED: t2_tick = t2_base & t2_smp_reg;
      default: t2_tick = 1'b0; // Stopped
    endcase
  end

  // Timer 2
  reload_timer16 u_timer2 (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(t2_tick),
    .auto_reload(ctrl_reg[`CTRL_RLD] == `RLD_MODE0),
    .ext_reload((ctrl_reg[`CTRL_RLD] == `RLD_MODE1) & rt_fall),
    .sw_load(wr_en & (paddr == `OFS_T2CNT)),
    .sw_data(pwdata[15:0]),
    .reload_value(cmp_val_reg[0]),
    .count(t2_cnt),
    .step(t2_step),
    .ovf(t2_ovf)
  );

  // Compare timer, always reloading
  reload_timer16 u_ctimer (
    .mclk(mclk),
    .rst_n(rst_n),
    .tick(ct_tick),
    .auto_reload(1'b1),
    .ext_reload(~ctrl_reg[`CTRL_CTRUN]), // Held at its reload value until started
    .sw_load(1'b0),
    .sw_data(16'h0000),
    .reload_value(ct_rld_reg),
    .count(ct_cnt),
    .step(ct_step),
    .ovf(ct_ovf)
  );

  // Five registers tied to timer 2, value used at once
  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : g_cc
      compare_channel #(.LATCHED(0)) u_cc (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cc_en_reg[g]),
        .mode1(cc_m1_reg[g]),
        .wr_value(cmp_val_reg[g]),
        .count(t2_cnt),
        .step(t2_step),
        .ovf(t2_ovf),
        .port_wr(wr_en & (paddr == `OFS_CCPORT)),
        .port_bit(pwdata[g]),
        .match(cc_match[g]),
        .pin(cc_pin[g])
      );
    end
    // Eight registers, each on either timer; the timer picks the mode
    for (g = 0; g < 8; g = g + 1) begin : g_cm
      compare_channel #(.LATCHED(1)) u_cm (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(cm_en_reg[g]),
        .mode1(cm_sel_reg[g]),
        .wr_value(cmp_val_reg[g+5]),
        .count(cm_sel_reg[g] ? ct_cnt : t2_cnt),
        .step(cm_sel_reg[g] ? ct_step : t2_step),
        .ovf(cm_sel_reg[g] ? ct_ovf : t2_ovf),
        .port_wr(wr_en & (paddr == `OFS_CMPORT)),
        .port_bit(pwdata[g]),
        .match(cm_match[g]),
        .pin(cm_pin[g])
      );
    end
  endgenerate

  // Mode 2 matches against timer 2
  assign set_hit = ctrl_reg[`CTRL_CMP2] & t2_step & (t2_cnt == set_compare_register);
  assign clr_hit = ctrl_reg[`CTRL_CMP2] & t2_step & (t2_cnt == clear_compare_register);

  // Concurrent port next value
  always @* begin
    ccm_next = ccm_reg;
    if (ctrl_reg[`CTRL_CMP2]) begin
      // Set first, clear wins on a tie
      if (set_hit) begin
        ccm_next = ccm_next | set_mask;
      end
      if (clr_hit) begin
        ccm_next = ccm_next & ~clear_mask;
      end
    end else if (ctrl_reg[`CTRL_CONC]) begin
      // Concurrent register match moves all eight shadow bits
      if (cc_match[4]) begin
        ccm_next = ccm_sh_reg;
      end
    end else if (wr_en && paddr == `OFS_CONCPORT) begin
      ccm_next = pwdata[7:0];
    end
  end

  // APB decode
  assign wr_en = psel & penable & pwrite;
  assign in_cc = (paddr[7:5] == `WIN_CC) && (paddr[4:2] < 3'h5) && (paddr[1:0] == 2'h0);
  assign in_cm = (paddr[7:5] == `WIN_CM) && (paddr[1:0] == 2'h0);
  assign mapped = in_cc | in_cm | ((paddr < 8'h40) && (paddr[1:0] == 2'h0) && (paddr != 8'h08));
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  // Events set status, set wins over clear
  assign int_ev = {cc_match, cm_match, ct_ovf, t2_ovf};
  assign irq = |(int_st_reg & int_msk_reg);

  // Register writes and port latches
  always @(posedge mclk) begin
    if (!rst_n) begin
      ctrl_reg <= 11'h000;
      ct_rld_reg <= 16'h0000;
      cm_en_reg <= 8'h00;
      cm_sel_reg <= 8'h00;
      cc_en_reg <= 5'h00;
      cc_m1_reg <= 5'h00;
      set_compare_register <= 16'h0000;
      clear_compare_register <= 16'h0000;
      set_mask <= 8'h00;
      clear_mask <= 8'h00;
      ccm_reg <= `PORT_RST;
      ccm_sh_reg <= `PORT_RST;
      int_st_reg <= {`INT_W{1'b0}};
      int_msk_reg <= {`INT_W{1'b0}};
      for (k = 0; k < 13; k = k + 1) begin
        cmp_val_reg[k] <= 16'h0000;
      end
    end else begin
      ccm_reg <= ccm_next;
      // Write one clears, new events win
      if (wr_en && paddr == `OFS_INTST) begin
        int_st_reg <= (int_st_reg & ~pwdata[`INT_W-1:0]) | int_ev;
      end else begin
        int_st_reg <= int_st_reg | int_ev;
      end
      if (wr_en) begin
        case (paddr)
          `OFS_CTRL: ctrl_reg <= pwdata[10:0];
          `OFS_CTRLD: ct_rld_reg <= pwdata[15:0];
          `OFS_CMEN: cm_en_reg <= pwdata[7:0];
          `OFS_CMSEL: cm_sel_reg <= pwdata[7:0];
          `OFS_CONCPORT: ccm_sh_reg <= pwdata[7:0];
          `OFS_SETCMP: set_compare_register <= pwdata[15:0];
          `OFS_CLRCMP: clear_compare_register <= pwdata[15:0];
          `OFS_MASKS: begin
            set_mask <= pwdata[7:0];
            clear_mask <= pwdata[15:8];
          end
          `OFS_CCCTL: begin
            cc_en_reg <= pwdata[4:0];
            cc_m1_reg <= pwdata[12:8];
          end
          `OFS_INTMSK: int_msk_reg <= pwdata[`INT_W-1:0];
          default: begin
            // Compare values; the eight latched ones take effect at overflow
            if (in_cc) begin
              cmp_val_reg[paddr[4:2]] <= pwdata[15:0];
            end else if (in_cm) begin
              cmp_val_reg[{1'b0, paddr[4:2]} + 4'h5] <= pwdata[15:0];
            end
          end
        endcase
      end
    end
  end

  // Read selection
  always @* begin
    rd_mux = 32'h00000000;
    case (paddr)
      `OFS_CTRL: rd_mux[10:0] = ctrl_reg;
      `OFS_T2CNT: rd_mux[15:0] = t2_cnt;
      `OFS_CTRLD: rd_mux[15:0] = ct_rld_reg;
      `OFS_CTCNT: rd_mux[15:0] = ct_cnt;
      `OFS_CMEN: rd_mux[7:0] = cm_en_reg;
      `OFS_CMSEL: rd_mux[7:0] = cm_sel_reg;
      `OFS_CMPORT: rd_mux[7:0] = cm_pin;
      `OFS_CONCPORT: rd_mux[7:0] = ccm_reg;
      `OFS_SETCMP: rd_mux[15:0] = set_compare_register;
      `OFS_CLRCMP: rd_mux[15:0] = clear_compare_register;
      `OFS_MASKS: rd_mux[15:0] = {clear_mask, set_mask};
      `OFS_CCCTL: rd_mux[12:0] = {cc_m1_reg, 3'h0, cc_en_reg};
      `OFS_CCPORT: rd_mux[4:0] = cc_pin;
      `OFS_INTST: rd_mux[`INT_W-1:0] = int_st_reg;
      `OFS_INTMSK: rd_mux[`INT_W-1:0] = int_msk_reg;
      default: begin
        if (in_cc) begin
          rd_mux[15:0] = cmp_val_reg[paddr[4:2]];
        end else if (in_cm) begin
          rd_mux[15:0] = cmp_val_reg[{1'b0, paddr[4:2]} + 4'h5];
        end
      end
    endcase
  end

  // Read data captured in the setup cycle, held through access
  always @(posedge mclk) begin
    if (!rst_n) begin
      prdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  // Concurrent pins follow their latch
  assign concurrent_output_pin = ccm_reg;
endmodule

// ---- core/compare_channel.v ----
// One compare register with its port latch in compare mode 0 or 1
`timescale 1ns/10ps
module compare_channel #(
  parameter LATCHED = 0 // 1: value takes effect at timer overflow
) (
  input wire mclk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire enable, // Compare function on
  input wire mode1, // 0: compare mode 0, 1: compare mode 1
  input wire [15:0] wr_value, // Value last written by software
  input wire [15:0] count, // Count of the assigned timer
  input wire step, // Pulse: assigned timer advanced
  input wire ovf, // Pulse: assigned timer overflowed
  input wire port_wr, // Software write to the port bit
  input wire port_bit, // Bit written to the port
  output wire match, // Pulse: compare match
  output reg pin // Port latch and pin
);

  reg [15:0] act_reg; // Value in use when latched
  reg shadow_reg; // Shadow latch of mode 1
  wire [15:0] cmp_value; // Value compared against the timer

  assign cmp_value = (LATCHED != 0) ? act_reg : wr_value;
  assign match = enable & step & (count == cmp_value);

  // Latched value follows the written one only at overflow
  always @(posedge mclk) begin
    if (!rst_n) begin
      act_reg <= 16'h0000;
    end else if (ovf) begin
      act_reg <= wr_value;
    end
  end

  // Port latch control
  always @(posedge mclk) begin
    if (!rst_n) begin
      pin <= 1'b1;
      shadow_reg <= 1'b1;
    end else if (enable && !mode1) begin
      // Timer events only, software writes dropped
      if (match) begin
        pin <= 1'b1;
      end else if (ovf) begin
        pin <= 1'b0;
      end
    end else if (enable) begin
      // Writes reach the shadow, match transfers it
      if (port_wr) begin
        shadow_reg <= port_bit;
      end
      if (match) begin
        pin <= shadow_reg;
      end
    end else if (port_wr) begin
      // Plain port
      pin <= port_bit;
      shadow_reg <= port_bit;
    end
  end
endmodule

// ---- core/reload_timer16.v ----
// Sixteen-bit up counter with reload value, software load and overflow pulse
`timescale 1ns/10ps
module reload_timer16 (
  input wire mclk, // System clock
  input wire rst_n, // Synchronous reset, active low
  input wire tick, // Count enable pulse
  input wire auto_reload, // Reload on overflow instead of wrap to zero
  input wire ext_reload, // Load reload value now
  input wire sw_load, // Software writes the count
  input wire [15:0] sw_data, // Count written by software
  input wire [15:0] reload_value, // Reload value
  output reg [15:0] count, // Current count
  output reg step, // Pulse: count advanced last edge
  output reg ovf // Pulse: count rolled over last edge
);

  // Counter with software load first, then external reload, then counting
  always @(posedge mclk) begin
    if (!rst_n) begin
      count <= 16'h0000;
      step <= 1'b0;
      ovf <= 1'b0;
    end else begin
      step <= tick & ~sw_load & ~ext_reload;
      ovf <= tick & ~sw_load & ~ext_reload & (count == 16'hFFFF);
      if (sw_load) begin
        count <= sw_data;
      end else if (ext_reload) begin
        count <= reload_value;
      end else if (tick) begin
        // Rollover reloads or wraps
        if (count == 16'hFFFF) begin
          count <= auto_reload ? reload_value : 16'h0000;
        end else begin
          count <= count + 16'h0001;
        end
      end
    end
  end
endmodule

// ---- dv/compare_capture_unit_asserts.sv ----
// Checker of the bus handshake, reset state and interrupt stickiness
`timescale 1ns/10ps
module ccu_asserts (
  input wire mclk, // Clock
  input wire rst_n, // Reset, active low
  input wire psel, // APB select
  input wire penable, // APB access
  input wire pwrite, // APB write
  input wire [7:0] paddr, // APB address
  input wire [31:0] prdata, // Read data
  input wire pready, // Ready
  input wire pslverr, // Error
  input wire [7:0] cm_pin, // Compare pins
  input wire [7:0] concurrent_output_pin, // Concurrent pins
  input wire irq // Interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Handshake: answer in the first access cycle and never outside one
  ready_one_a: assert property (psel && !penable |=> pready) else $error("ready late");
  ready_only_a: assert property (pready == (psel && penable)) else $error("ready outside access");
  // Refusal of the hole at 08, none for the timer count
  err_hole_a: assert property (pready && paddr == 8'h08 |-> pslverr) else $error("hole not refused");
  err_none_a: assert property (pready && paddr == 8'h04 |-> !pslverr) else $error("mapped refused");
  err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read set");
  // Read data stands past the access
  rdata_hold_a: assert property (pready |=> $stable(prdata)) else $error("read data moved");
  // Pins high and interrupt low on leaving reset
  reset_pins_a: assert property ($rose(rst_n) |-> cm_pin == 8'hFF && concurrent_output_pin == 8'hFF && !irq)
    else $error("reset state wrong");
  // Interrupt falls only through a register write
  irq_sticky_a: assert property ($fell(irq) |-> $past(pready && pwrite)) else $error("irq not sticky");
endmodule

bind compare_capture_unit ccu_asserts i_chk (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cm_pin(cm_pin),
  .concurrent_output_pin(concurrent_output_pin), .irq(irq));

// ---- dv/compare_capture_unit_test.sv ----
// Testbench of the compare unit: bus tasks and directed scenarios
`timescale 1ns/10ps
`include "ccu_consts.vh"
module compare_capture_unit_test;
  logic mclk; // Clock
  logic rst_n; // Reset, active low
  logic psel; // APB select
  logic penable; // APB access
  logic pwrite; // APB write
  logic [7:0] paddr; // APB address
  logic [31:0] pwdata; // APB write data
  wire [31:0] prdata; // Read data
  wire pready; // Ready
  wire pslverr; // Error
  wire gate_event; // Gate or event pin
  wire reload_trig; // Reload trigger pin
  wire [4:0] cc_pin; // Timer 2 register pins
  wire [7:0] cm_pin; // Compare pins
  wire [7:0] conc_pin; // Concurrent pins
  wire irq; // Interrupt
  wire [20:0] pins = {cc_pin, cm_pin, conc_pin}; // All pins
  logic [31:0] rdat; // Last read data
  logic rerr; // Last error flag
  logic [15:0] c0; // First count of a rate check
  int n_mismatch = 0; // Mismatches
  int checked = 0; // Comparisons
  int cyc = 0; // Cycles run
  compare_capture_unit i_dut (.mclk(mclk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer2_gate_event_input(gate_event), .reload_trigger_input(reload_trig), .cc_pin(cc_pin),
    .cm_pin(cm_pin), .concurrent_output_pin(conc_pin), .irq(irq));
  pin_model i_pins (.mclk(mclk), .gate_event(gate_event), .reload_trig(reload_trig));
  // Clock of 5 ns
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Verdict and end of run
  task end_sim;
    if (n_mismatch == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      end_sim;
    end
  end
  // Compare one value
  task check(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // One bus transfer: setup, access until ready, release
  task xfer(input logic w, input [7:0] a, input [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    xfer(1'b0, a, 32'h0);
    check($sformatf("reg %h", a), e, rdat);
  endtask
  // Counts advanced over a window of gap plus three cycles
  task rate(input [7:0] a, input int gap, input int e);
    xfer(1'b0, a, 32'h0);
    c0 = rdat[15:0];
    repeat (gap) @(posedge mclk);
    xfer(1'b0, a, 32'h0);
    check("count step", {16'h0, e[15:0]}, {16'h0, rdat[15:0] - c0});
  endtask
  // Wait, bounded, until masked pins show a pattern
  task wait_pins(input [20:0] e, input [20:0] m);
    int n;
    n = 0;
    while ((pins & m) !== e && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    check("pin wait", 32'h0, {31'h0, n == 1000});
  endtask
  // Directed scenarios
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    check("pins", 32'h1FFFFF, {11'h0, pins});
    check("irq", 32'h0, {31'h0, irq});
    wr(8'h08, 32'hFFFF);
    check("write error", 32'h1, {31'h0, rerr});
    rdc(8'h08, 32'h0);
    rdc(`OFS_T2CNT, 32'h0);
    // Timer 2 prescaler and compare timer prescaler
    for (int s = 0; s < 2; s++) begin
      wr(`OFS_CTRL, 32'h1 | (s << 2));
      rate(`OFS_T2CNT, 237, 20 >> s);
    end
    for (int p = 0; p < 8; p++) begin
      wr(`OFS_CTRL, 32'h100 | (p << 5));
      rate(`OFS_CTCNT, (20 << p) - 3, 10);
    end
    // Gated, then event counting
    wr(`OFS_CTRL, 32'h3);
    i_pins.drive(1'b0, 1'b1, 30);
    rate(`OFS_T2CNT, 237, 0);
    i_pins.drive(1'b1, 1'b1, 30);
    rate(`OFS_T2CNT, 237, 20);
    wr(`OFS_CTRL, 32'h2);
    wr(`OFS_T2CNT, 32'h0);
    i_pins.events(5);
    rdc(`OFS_T2CNT, 32'h5);
    // Reload by trigger pin
    wr(8'h40, 32'hABCD);
    wr(`OFS_CTRL, 32'h10);
    wr(`OFS_T2CNT, 32'h100);
    rdc(`OFS_T2CNT, 32'h100);
    i_pins.drive(1'b1, 1'b0, 23);
    i_pins.drive(1'b1, 1'b1, 20);
    rdc(`OFS_T2CNT, 32'hABCD);
    // Reload on overflow, flag and interrupt
    wr(8'h40, 32'h1234);
    wr(`OFS_INTST, 32'h7FFF);
    wr(`OFS_INTMSK, 32'h1);
    wr(`OFS_CTRL, 32'h9);
    wr(`OFS_T2CNT, 32'hFFFE);
    repeat (40) @(posedge mclk);
    xfer(1'b0, `OFS_T2CNT, 32'h0);
    check("reloaded", 32'h1, {31'h0, rdat[15:0] >= 16'h1234 && rdat[15:0] <= 16'h1236});
    xfer(1'b0, `OFS_INTST, 32'h0);
    check("t2 flag", 32'h1, {31'h0, rdat[0]});
    check("irq", 32'h1, {31'h0, irq});
    wr(`OFS_INTST, 32'h1);
    @(posedge mclk);
    check("irq", 32'h0, {31'h0, irq});
    // Compare mode 0 on channel 0, mode 1 on register 1
    wr(8'h40, 32'hFFF0);
    wr(8'h60, 32'hFFF8);
    wr(`OFS_CMSEL, 32'h0);
    wr(`OFS_CMEN, 32'h1);
    wr(8'h44, 32'hFFF6);
    wr(8'h50, 32'hFFF8);
    wr(`OFS_CCCTL, 32'h1212);
    wr(`OFS_T2CNT, 32'hFFF0);
    wait_pins(21'h0, 21'h100);
    wr(8'h60, 32'hFFFC);
    wr(`OFS_CMPORT, 32'hFF);
    @(posedge mclk);
    check("cm0 pin", 32'h0, {31'h0, cm_pin[0]});
    wait_pins(21'h100, 21'h100);
    rdc(`OFS_T2CNT, 32'hFFF8);
    wait_pins(21'h0, 21'h100);
    wr(`OFS_CCPORT, 32'h0);
    @(posedge mclk);
    check("cc1 pin", 32'h1, {31'h0, cc_pin[1]});
    wait_pins(21'h0, 21'h20000);
    rdc(`OFS_T2CNT, 32'hFFF6);
    wait_pins(21'h100, 21'h100);
    rdc(`OFS_T2CNT, 32'hFFFC);
    xfer(1'b0, `OFS_INTST, 32'h0);
    check("cm0 flag", 32'h1, {31'h0, rdat[2]});
    wr(`OFS_CMEN, 32'h0);
    // Compare mode 2, then concurrent compare
    wr(`OFS_SETCMP, 32'hFFF4);
    wr(`OFS_CLRCMP, 32'hFFFA);
    wr(`OFS_MASKS, 32'h0305);
    wr(`OFS_CTRL, 32'h209);
    wait_pins(21'hFC, 21'hFF);
    rdc(`OFS_T2CNT, 32'hFFFA);
    wait_pins(21'hFD, 21'hFF);
    rdc(`OFS_T2CNT, 32'hFFF4);
    wr(`OFS_CTRL, 32'h409);
    wr(`OFS_CONCPORT, 32'h5A);
    @(posedge mclk);
    check("conc pins", 32'hFD, {24'h0, conc_pin});
    wait_pins(21'h5A, 21'hFF);
    rdc(`OFS_T2CNT, 32'hFFF8);
    // Compare timer reload, overflow flag, compare register 1 in mode 1
    wr(`OFS_CTRLD, 32'hFFF0);
    wr(8'h64, 32'hFFF8);
    wr(`OFS_CMSEL, 32'h2);
    wr(`OFS_CMEN, 32'h2);
    wr(`OFS_INTST, 32'h7FFF);
    wr(`OFS_CMPORT, 32'h0);
    wr(`OFS_CTRL, 32'h160);
    wait_pins(21'h0, 21'h200);
    rdc(`OFS_CTCNT, 32'hFFF8);
    wr(`OFS_CMPORT, 32'h2);
    wait_pins(21'h200, 21'h200);
    rdc(`OFS_CTCNT, 32'hFFF8);
    xfer(1'b0, `OFS_INTST, 32'h0);
    check("ct flag", 32'h1, {31'h0, rdat[1]});
    end_sim;
  end
endmodule

// ---- dv/pin_model.sv ----
// Model of the pins beside the unit: gate, event and reload trigger sources
`timescale 1ns/10ps
module pin_model (
  input wire mclk, // Clock
  output logic gate_event, // Gate or event level
  output logic reload_trig // Reload trigger level
);
  // Both lines idle high
  initial begin
    gate_event = 1'b1;
    reload_trig = 1'b1;
  end
  // Set both levels after an edge, then hold them
  task drive(input logic g, input logic r, input int n);
    @(posedge mclk);
    gate_event <= g;
    reload_trig <= r;
    repeat (n) @(posedge mclk);
  endtask
  // Falling edges, each level held two machine cycles
  task events(input int k);
    repeat (k) begin
      drive(1'b0, 1'b1, 23);
      drive(1'b1, 1'b1, 23);
    end
  endtask
endmodule

// ---- include/ccu_consts.vh ----
// Constants of the compare unit: register offsets, fields, reset values and counts
`ifndef CCU_CONSTS_VH
`define CCU_CONSTS_VH

// Oscillator clocks per machine cycle
`define OSC_PER_MC 4'd12
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_T2CNT 8'h04
`define OFS_CTRLD 8'h0C
`define OFS_CTCNT 8'h10
`define OFS_CMEN 8'h14
`define OFS_CMSEL 8'h18
`define OFS_CMPORT 8'h1C
`define OFS_CONCPORT 8'h20
`define OFS_SETCMP 8'h24
`define OFS_CLRCMP 8'h28
`define OFS_MASKS 8'h2C
`define OFS_CCCTL 8'h30
`define OFS_CCPORT 8'h34
`define OFS_INTST 8'h38
`define OFS_INTMSK 8'h3C
// Window of the five timer 2 registers and of the eight compare registers
`define WIN_CC 3'h2
`define WIN_CM 3'h3
// Control fields
`define CTRL_T2SRC 1:0
`define CTRL_T2PS 2
`define CTRL_RLD 4:3
`define CTRL_CTPS 7:5
`define CTRL_CTRUN 8
`define CTRL_CMP2 9
`define CTRL_CONC 10
// Timer 2 input sources and reload modes
`define SRC_STOP 2'h0
`define SRC_TIMER 2'h1
`define SRC_EVENT 2'h2
`define SRC_GATED 2'h3
`define RLD_MODE0 2'h1
`define RLD_MODE1 2'h2
// Reset value of port latches
`define PORT_RST 8'hFF
// Interrupt status width
`define INT_W 15
`endif
